// ### valve_pkg.sv
// Purpose: shared constants and carrier types for the valve actuator command logic
// Assumes: 200 MHz system clock
// Notes: times kept in their own units, cycle counts derived here
package valve_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MIN_CLOSURE_MS = 20;
  localparam int unsigned MENU_HOLD_S = 5;
  localparam int unsigned MIN_CLOSURE_CYC = (CLK_HZ / 1000) * MIN_CLOSURE_MS;
  localparam longint unsigned MENU_HOLD_CYC = longint'(CLK_HZ) * MENU_HOLD_S;
  localparam int unsigned STEP_TIME_CYC = 1000;
  localparam int unsigned POS_W = 6;
  localparam logic [5:0] NUM_POS_DEFAULT = 6'h0a;
  localparam logic [5:0] HOME_INDEX = 6'h01;
  localparam logic [5:0] POS_A_INDEX = 6'h01;
  localparam logic [5:0] POS_B_INDEX = 6'h02;

  typedef enum logic {
    CFG_TWO_POS,
    CFG_MULTI_POS
  } cfg_mode_t;

  // Active-low command pins, one bit each
  typedef struct packed {
    logic up_n;
    logic down_n;
    logic home_n;
    logic pos_a_n;
    logic pos_b_n;
    logic step_n;
    logic home_pin_n;
  } cmd_pins_t;

  // Qualified one-cycle command pulses
  typedef struct packed {
    logic up;
    logic down;
    logic home;
    logic pos_a;
    logic pos_b;
    logic step;
    logic home_pin;
  } cmd_pulses_t;

  typedef struct packed {
    logic pos_a_stat;
    logic pos_b_stat;
    logic home_stat;
    logic run_stat;
  } status_t;

endpackage

// ### input_qualifier.sv
// Purpose: qualify one active-low discrete input, emit a pulse on qualified assertion
// Assumes: input synchronous to the clock
// Notes: also reports a long-hold pulse once after HOLD_CYC cycles held
`default_nettype none
module input_qualifier
  import valve_pkg::*;
#(
  parameter int unsigned MIN_CYC = MIN_CLOSURE_CYC,
  parameter longint unsigned HOLD_CYC = MENU_HOLD_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Pin and results
  input wire logic pin_n_in,
  output logic press_out,
  output logic hold_out
);

  typedef struct packed {
    logic [39:0] count;
    logic press;
    logic hold;
  } q_state_t;

  q_state_t st;
  q_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.press = 1'b0;
    next_st.hold = 1'b0;
    if (pin_n_in) begin
      next_st.count = '0;
    end else if (st.count != 40'hff_ffff_ffff) begin
      next_st.count = st.count + 40'h1;
      // Edge fires once when closure reaches the minimum time; release does nothing
      if (st.count + 40'h1 == 40'(MIN_CYC)) begin
        next_st.press = 1'b1;
      end
      if (st.count + 40'h1 == 40'(HOLD_CYC)) begin
        next_st.hold = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign press_out = st.press;
  assign hold_out = st.hold;

endmodule
`default_nettype wire

// ### position_mover.sv
// Purpose: move the actuator one index per step tick toward a target
// Assumes: target changes may arrive at any time
// Notes: direction of travel chosen by caller; stands in for the motor drive
`default_nettype none
module position_mover
  import valve_pkg::*;
#(
  parameter int unsigned STEP_CYC = STEP_TIME_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Command
  input wire logic [POS_W-1:0] num_pos_in,
  input wire logic [POS_W-1:0] target_in,
  input wire logic fwd_in,
  // Position
  output logic [POS_W-1:0] pos_out,
  output logic moving_out
);

  typedef struct packed {
    logic [31:0] tick;
    logic [POS_W-1:0] pos;
  } m_state_t;

  m_state_t st;
  m_state_t next_st;

  always_comb begin
    next_st = st;
    if (st.pos == target_in) begin
      next_st.tick = '0;
    end else if (st.tick + 32'h1 >= STEP_CYC) begin
      next_st.tick = '0;
      if (fwd_in) begin
        next_st.pos = (st.pos >= num_pos_in) ? HOME_INDEX : st.pos + 6'h01;
      end else begin
        next_st.pos = (st.pos <= HOME_INDEX) ? num_pos_in : st.pos - 6'h01;
      end
    end else begin
      next_st.tick = st.tick + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '{tick: '0, pos: HOME_INDEX};
    end else begin
      st <= next_st;
    end
  end

  assign pos_out = st.pos;
  assign moving_out = (st.pos != target_in);

endmodule
`default_nettype wire

// ### valve_actuator_discrete_control.sv
// Purpose: discrete-input position command logic for a stepper rotary valve actuator
// Assumes: inputs synchronous to ref_clk_in, active low (pulled to common)
// Notes: config mode and position count are inputs; menu contents are outside
//
// Overview of operation
// - Two-position up goes to B
// - Multiposition up advances one index
// - Two-position down goes to A
// - Multiposition down goes back one index
// - Two-position home goes to A
// - Multiposition home goes to index one
// - Home held five seconds enters menu
// - Up in menu exits unchanged
// - Input asserted when pulled to common
// - A closure held 20 ms moves to A
// - Release never starts motion
// - Qualified B closure moves to B
// - A and B status high on arrival
// - Multiposition step closure 20 ms moves one position, direction set by dir_fwd_in
// - Multiposition home pin drives to index one
// - Home status low at index one
// - Run status low while motor runs
// - New command during move retargets
`default_nettype none
module valve_actuator_discrete_control
  import valve_pkg::*;
#(
  parameter int unsigned MIN_CYC = MIN_CLOSURE_CYC,
  parameter longint unsigned HOLD_CYC = MENU_HOLD_CYC,
  parameter int unsigned STEP_CYC = STEP_TIME_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Configuration
  input wire logic multi_mode_in,
  input wire logic dir_fwd_in,
  input wire logic [POS_W-1:0] num_pos_in,
  // Discrete command pins, active low
  input wire cmd_pins_t pins_in,
  // Feedback
  output status_t status_out,
  output logic menu_active_out,
  output logic [POS_W-1:0] position_out
);

  cmd_pulses_t press;
  logic [6:0] hold;
  logic [POS_W-1:0] pos;
  logic moving;

  // Each pin is asserted low, pulled to common by logic or contact
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_up (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.up_n),
    .press_out(press.up), .hold_out(hold[0]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_down (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.down_n),
    .press_out(press.down), .hold_out(hold[1]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_home (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.home_n),
    .press_out(press.home), .hold_out(hold[2]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_pos_a (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.pos_a_n),
    .press_out(press.pos_a), .hold_out(hold[3]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_pos_b (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.pos_b_n),
    .press_out(press.pos_b), .hold_out(hold[4]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_step (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.step_n),
    .press_out(press.step), .hold_out(hold[5]));
  input_qualifier #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC)) u_home_pin (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_n_in(pins_in.home_pin_n),
    .press_out(press.home_pin), .hold_out(hold[6]));

  typedef enum logic {
    ST_RUN,
    ST_MENU
  } ctl_mode_t;

  typedef struct packed {
    ctl_mode_t mode;
    logic [POS_W-1:0] target;
    logic fwd;
    status_t status;
    logic menu;
    logic [POS_W-1:0] pos;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  function automatic logic [POS_W-1:0] next_index(input logic [POS_W-1:0] idx, input logic [POS_W-1:0] n,
                                                   input logic up);
    if (up) begin
      next_index = (idx >= n) ? HOME_INDEX : idx + 6'h01;
    end else begin
      next_index = (idx <= HOME_INDEX) ? n : idx - 6'h01;
    end
  endfunction

  position_mover #(.STEP_CYC(STEP_CYC)) u_mover (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .num_pos_in(multi_mode_in ? num_pos_in : POS_B_INDEX),
    .target_in(st.target),
    .fwd_in(st.fwd),
    .pos_out(pos),
    .moving_out(moving)
  );

  always_comb begin
    next_st = st;
    case (st.mode)
      ST_RUN: begin
        // Long home hold enters the menu instead of moving
        if (hold[2]) begin
          next_st.mode = ST_MENU;
          next_st.target = pos;
        end else if (!multi_mode_in) begin
          // Any up, down, home, A or B command replaces the current target, even mid-move
          // A target equal to the current position makes no motion
          if (press.up || press.pos_b) begin
            next_st.target = POS_B_INDEX;
            next_st.fwd = 1'b1;
          end else if (press.down || press.home || press.pos_a) begin
            next_st.target = POS_A_INDEX;
            next_st.fwd = 1'b0;
          end
        end else begin
          if (press.up) begin
            next_st.target = next_index(st.target, num_pos_in, 1'b1);
            next_st.fwd = 1'b1;
          end else if (press.down) begin
            next_st.target = next_index(st.target, num_pos_in, 1'b0);
            next_st.fwd = 1'b0;
          end else if (press.step) begin
            next_st.target = next_index(st.target, num_pos_in, dir_fwd_in);
            next_st.fwd = dir_fwd_in;
          end else if (press.home) begin
            next_st.target = HOME_INDEX;
            next_st.fwd = 1'b0;
          end else if (press.home_pin) begin
            next_st.target = HOME_INDEX;
            next_st.fwd = dir_fwd_in;
          end
        end
      end
      ST_MENU: begin
        // Up leaves the menu with nothing changed
        if (press.up) begin
          next_st.mode = ST_RUN;
        end
      end
      default: begin
        next_st.mode = ST_RUN;
      end
    endcase
    next_st.menu = (next_st.mode == ST_MENU);
    next_st.pos = pos;
    next_st.status.pos_a_stat = !multi_mode_in && !moving && (pos == POS_A_INDEX);
    next_st.status.pos_b_stat = !multi_mode_in && !moving && (pos == POS_B_INDEX);
    next_st.status.home_stat = !(pos == HOME_INDEX && !moving);
    next_st.status.run_stat = !moving;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '{mode: ST_RUN, target: HOME_INDEX, fwd: 1'b1,
              status: '{pos_a_stat: 1'b0, pos_b_stat: 1'b0, home_stat: 1'b1, run_stat: 1'b1},
              menu: 1'b0, pos: HOME_INDEX};
    end else begin
      st <= next_st;
    end
  end

  assign status_out = st.status;
  assign menu_active_out = st.menu;
  assign position_out = st.pos;

endmodule
`default_nettype wire

// ### valve_props.sv
// Purpose: port checker for the valve command logic
// Assumes: pins active low, status registered in the same cycle as position
// Notes: helper counters time each closure
`default_nettype none
module valve_props
  import valve_pkg::*;
#(
  parameter int unsigned MIN_CYC = 20,
  parameter longint unsigned HOLD_CYC = 200,
  parameter int unsigned STEP_CYC = 16
) (
  // Clock, reset and inputs
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic multi_mode_in,
  input wire logic [POS_W-1:0] num_pos_in,
  input wire cmd_pins_t pins_in,
  // Outputs
  input wire status_t status_out,
  input wire logic menu_active_out,
  input wire logic [POS_W-1:0] position_out
);
  localparam int RUN_WAIT = STEP_CYC + 4;
  logic [7:0] any_cnt;
  logic [7:0] home_cnt;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      any_cnt <= 8'h00;
      home_cnt <= 8'h00;
    end else begin
      any_cnt <= (&pins_in) ? 8'h00 : any_cnt + 8'(any_cnt != 8'hff);
      home_cnt <= pins_in.home_n ? 8'h00 : home_cnt + 8'(home_cnt != 8'hff);
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_home_held;
    home_cnt >= HOLD_CYC - 2 && home_cnt <= HOLD_CYC + 6;
  endsequence
  sequence s_up_held;
    !pins_in.up_n && any_cnt >= MIN_CYC;
  endsequence
  a_run_needs_hold: assert property ($fell(status_out.run_stat) |-> any_cnt >= MIN_CYC)
    else $error("motion without a qualified closure");
  a_run_makes_progress: assert property (!status_out.run_stat |->
    ##[1:RUN_WAIT] ($changed(position_out) || status_out.run_stat))
    else $error("run status low without progress");
  a_move_only_running: assert property ($changed(position_out) |-> !$past(status_out.run_stat))
    else $error("position moved while idle");
  a_one_index_step: assert property ($changed(position_out) |->
    position_out == $past(position_out) + 6'h01 || position_out + 6'h01 == $past(position_out) ||
    (position_out == HOME_INDEX && $past(position_out) == num_pos_in) ||
    (position_out == num_pos_in && $past(position_out) == HOME_INDEX))
    else $error("position jumped");
  // Status and position are registered from one snapshot, so compare in the same cycle;
  // the first cycle after reset still shows the reset status values
  a_home_stat_level: assert property (multi_mode_in && $past(rstn_in) && status_out.run_stat |->
    status_out.home_stat == (position_out != HOME_INDEX))
    else $error("home status wrong");
  a_ab_stat_level: assert property (!multi_mode_in && $past(rstn_in) && status_out.run_stat |->
    status_out.pos_a_stat == (position_out == POS_A_INDEX) &&
    status_out.pos_b_stat == (position_out == POS_B_INDEX))
    else $error("position status wrong");
  a_menu_on_hold: assert property ($rose(menu_active_out) |-> s_home_held)
    else $error("menu entered without long hold");
  a_menu_exit_up: assert property ($fell(menu_active_out) |-> s_up_held)
    else $error("menu left without up press");
  a_menu_no_motion: assert property (menu_active_out |=> $stable(position_out))
    else $error("motion in menu");
endmodule
bind valve_actuator_discrete_control valve_props #(.MIN_CYC(MIN_CYC), .HOLD_CYC(HOLD_CYC), .STEP_CYC(STEP_CYC))
  u_valve_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .multi_mode_in(multi_mode_in),
  .num_pos_in(num_pos_in), .pins_in(pins_in), .status_out(status_out), .menu_active_out(menu_active_out),
  .position_out(position_out));
`default_nettype wire

// ### contact_source.sv
// Purpose: contact closure source for the command pins
// Assumes: one closure at a time, open pins pulled high
// Notes: index counts from the lsb, home pin is 0
`default_nettype none
module contact_source
  import valve_pkg::*;
(
  // Clock and pins
  input wire logic ref_clk_in,
  output var cmd_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_out = '1;
  task automatic press(input int idx, input int cyc);
    @(negedge ref_clk_in);
    pins_out[idx] = 1'b0;
    repeat (cyc) @(negedge ref_clk_in);
    pins_out = '1;
  endtask
endmodule
`default_nettype wire

// ### tb_valve_actuator_discrete_control.sv
// Purpose: self-checking bench for the valve command logic
// Assumes: shortened counts, closure 20, hold 200, step 16 cycles
// Notes: closures come from contact_source
`default_nettype none
module tb_valve_actuator_discrete_control;
  import valve_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN = 20;
  localparam int HOLD = 200;
  localparam int STEP = 16;
  localparam int UP = 6, DN = 5, HM = 4, PA = 3, PB = 2, ST = 1, HP = 0;
  logic ref_clk_in;
  logic rstn_in;
  logic multi_mode_in;
  logic dir_fwd_in;
  logic [POS_W-1:0] num_pos_in;
  cmd_pins_t pins;
  status_t st;
  logic menu;
  logic [POS_W-1:0] pos;
  int errors;
  int comparisons;
  logic watch;
  logic idle_seen;
  contact_source u_contact_source (.ref_clk_in(ref_clk_in), .pins_out(pins));
  valve_actuator_discrete_control #(.MIN_CYC(MIN), .HOLD_CYC(HOLD), .STEP_CYC(STEP))
    u_valve_actuator_discrete_control (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .multi_mode_in(multi_mode_in), .dir_fwd_in(dir_fwd_in), .num_pos_in(num_pos_in), .pins_in(pins),
    .status_out(st), .menu_active_out(menu), .position_out(pos));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // Flags a rest at the old target during a retarget
  always @(posedge ref_clk_in) begin
    if (watch && st.run_stat === 1'b1 && pos === 6'h01) idle_seen <= 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (st.run_stat !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      tally_and_finish();
    end
    repeat (2) @(negedge ref_clk_in);
  endtask
  task automatic go(input int idx, input logic [7:0] exp);
    u_contact_source.press(idx, MIN + 5);
    wait_idle();
    check(pos, exp);
  endtask
  task automatic s_two_pos;
    go(PB, 8'h02);
    check(st.pos_b_stat, 8'h01);
    go(UP, 8'h02);
    go(PA, 8'h01);
    check(st.pos_a_stat, 8'h01);
    go(DN, 8'h01);
    go(HM, 8'h01);
    go(UP, 8'h02);
    go(HM, 8'h01);
    go(UP, 8'h02);
    go(DN, 8'h01);
  endtask
  task automatic s_short;
    u_contact_source.press(PB, MIN - 1);
    repeat (MIN) @(negedge ref_clk_in);
    check(st.run_stat, 8'h01);
    check(pos, 8'h01);
  endtask
  task automatic s_menu;
    u_contact_source.press(HM, HOLD + 10);
    check(menu, 8'h01);
    go(UP, 8'h01);
    check(menu, 8'h00);
  endtask
  task automatic s_multi;
    multi_mode_in = 1'b1;
    go(UP, 8'h02);
    go(DN, 8'h01);
    check(st.home_stat, 8'h00);
    go(DN, 8'h0a);
    check(st.home_stat, 8'h01);
    go(HM, 8'h01);
    go(UP, 8'h02);
    go(ST, 8'h03);
    dir_fwd_in = 1'b0;
    go(ST, 8'h02);
    go(HP, 8'h01);
    dir_fwd_in = 1'b1;
    go(ST, 8'h02);
    go(HP, 8'h01);
  endtask
  task automatic s_retarget;
    go(ST, 8'h02);
    u_contact_source.press(HP, MIN + 5);
    idle_seen = 1'b0;
    watch = 1'b1;
    u_contact_source.press(UP, MIN + 5);
    wait_idle();
    watch = 1'b0;
    check(idle_seen, 8'h00);
    check(pos, 8'h02);
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    watch = 1'b0;
    idle_seen = 1'b0;
    rstn_in = 1'b0;
    multi_mode_in = 1'b0;
    dir_fwd_in = 1'b1;
    num_pos_in = 6'h0a;
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    check(pos, 8'h01);
    check({st.pos_a_stat, st.pos_b_stat, st.run_stat}, 8'h05);
    s_two_pos();
    s_short();
    s_menu();
    s_multi();
    s_retarget();
    tally_and_finish();
  end
endmodule
`default_nettype wire
